// file: bench/dee_core_model.sv
/* Core model: register and table accesses as Avalon-MM master cycles.
   Assumes the same clock as the controller. */
`timescale 1ns/100ps
`include "dee_defs.svh"
module dee_core_model (
    input  wire logic        clock_in,            // Clock
    input  wire logic [31:0] avs_readdata_out,    // Read data
    input  wire logic        avs_waitrequest_out, // Wait
    output logic      [5:0]  avs_address_in,      // Address
    output logic             avs_read_in,         // Read
    output logic             avs_write_in,        // Write
    output logic      [31:0] avs_writedata_in     // Write data
);
    initial {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
    // Held until wait is sampled low; one idle edge follows
    task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= ~w;
        @(posedge clock_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
        q = avs_readdata_out;
        {avs_write_in, avs_read_in} <= 2'b00;
        // Released data shows the inverse, never stale data
        avs_writedata_in <= ~d;
        @(posedge clock_in);
    endtask
    // Keys stay the last two writes before the start write
    task automatic start_cycle(input logic [15:0] ctl, input logic pre);
        logic [31:0] q;
        if (pre) access(1'b1, `DEE_OFS_CONTROL, {16'h0000, ctl}, q);
        access(1'b1, `DEE_OFS_UNLOCK_KEY, {24'h000000, `DEE_KEY_FIRST}, q);
        access(1'b1, `DEE_OFS_UNLOCK_KEY, {24'h000000, `DEE_KEY_SECOND}, q);
        access(1'b1, `DEE_OFS_CONTROL, {16'h0000, ctl | 16'h8000}, q);
    endtask
endmodule // dee_core_model

// file: bench/dee_ctrl_checker.sv
/* Port assertions of dee_ctrl, bound to every instance.
   Assumes PROG_CYCLES is handed on from the instance. */
`timescale 1ns/100ps
`include "dee_defs.svh"
module dee_ctrl_checker #(parameter int PROG_CYCLES = 40) (
    input wire logic        clock_in,             // Clock
    input wire logic        nrst_in,              // Reset
    input wire logic        master_clear_in,      // Abort
    input wire logic        watchdog_reset_in,    // Abort
    input wire logic [5:0]  avs_address_in,       // Address
    input wire logic        avs_read_in,          // Read
    input wire logic        avs_write_in,         // Write
    input wire logic [31:0] avs_writedata_in,     // Data in
    input wire logic [31:0] avs_readdata_out,     // Data out
    input wire logic        avs_waitrequest_out,  // Wait
    input wire logic        busy_out,             // Busy
    input wire logic        memory_done_flag_out, // Done
    input wire logic        program_error_out     // Error
);
    logic [15:0] busy_cnt;
    logic        abort, go_wr, done_wr, start_wr;
    assign abort = master_clear_in | watchdog_reset_in;
    assign go_wr = avs_write_in & ~avs_waitrequest_out & avs_writedata_in[15]
        & (avs_address_in == `DEE_OFS_CONTROL);
    assign done_wr = avs_write_in & ~avs_waitrequest_out
        & (avs_address_in == `DEE_OFS_DONE_STATUS);
    // Busy cycles counted so the cycle length is exact
    always_ff @(posedge clock_in or negedge nrst_in)
        if (!nrst_in) {busy_cnt, start_wr} <= 17'h00000;
        else {busy_cnt, start_wr} <= {busy_out ? busy_cnt + 16'h0001 : 16'h0000, go_wr};
    default clocking dc @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    wait_one_a: assert property (
        (avs_read_in | avs_write_in) && avs_waitrequest_out && !abort |=> !avs_waitrequest_out)
        else $error("bus answer late");
    wait_again_a: assert property (
        (avs_read_in | avs_write_in) && !avs_waitrequest_out
        |=> avs_waitrequest_out || !(avs_read_in || avs_write_in))
        else $error("wait not raised again");
    cycle_len_a: assert property (
        $fell(busy_out) && !$past(abort) |-> busy_cnt == 16'(PROG_CYCLES))
        else $error("cycle length wrong");
    start_hold_a: assert property (
        busy_out && !abort && busy_cnt < 16'(PROG_CYCLES - 1) |=> busy_out)
        else $error("cycle ended early");
    done_set_a: assert property ($fell(busy_out) && !$past(abort) |-> memory_done_flag_out)
        else $error("done flag not set");
    done_hold_a: assert property (memory_done_flag_out && !done_wr |=> memory_done_flag_out)
        else $error("done flag lost");
    abort_err_a: assert property (busy_out && abort |=> program_error_out && !busy_out)
        else $error("abort not flagged");
    start_cause_a: assert property ($rose(busy_out) |-> start_wr)
        else $error("start without start write");
endmodule // dee_ctrl_checker

bind dee_ctrl dee_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) u_dee_ctrl_checker (.*);

// file: bench/dee_ctrl_test.sv
/* Bench of dee_ctrl: refused starts, random word and block runs, aborts.
   Assumes dee_core_model as master and the bound checker. */
`timescale 1ns/100ps
`include "dee_defs.svh"
module dee_ctrl_test;
    localparam int PC = 40;
    logic        clock_in = 1'b0, nrst_in = 1'b0;
    logic        master_clear_in = 1'b0, watchdog_reset_in = 1'b0;
    logic [5:0]  avs_address_in;
    logic        avs_read_in, avs_write_in, avs_waitrequest_out;
    logic        busy_out, memory_done_flag_out, program_error_out;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic [15:0] exp_mem [64];
    logic [15:0] lat [16];
    int          miscompares = 0, num_checks = 0, seed = 88968, i;
    always #25 clock_in = ~clock_in;
    dee_ctrl #(.PROG_CYCLES(PC)) u_dee_ctrl (.*);
    dee_core_model u_dee_core_model (.*);
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        u_dee_core_model.access(w, a, {16'h0000, d}, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tbl(input logic w, input int n, input logic [15:0] d);
        acc(1'b1, `DEE_OFS_TABLE_PAGE, {8'h00, `DEE_EE_PAGE});
        acc(1'b1, `DEE_OFS_TABLE_OFFSET, 16'(n * 2));
        acc(w, `DEE_OFS_TABLE_DATA, d);
    endtask
    task automatic check_mem;
        for (int j = 0; j < 64; j++) begin
            tbl(1'b0, j, 16'h0000);
            chk(q, {16'h0000, exp_mem[j]});
        end
    endtask
    function automatic logic [15:0] expect_word(input logic [15:0] ctl, input int j);
        return ctl[`DEE_OP_ERASE] ? `DEE_ERASED : lat[j % 16];
    endfunction
    // Start, poke the register mid-cycle, wait, then clear the done flag
    task automatic run(input logic [15:0] ctl, input int n);
        int k;
        acc(1'b1, `DEE_OFS_ADDR_LOW, 16'(n * 2));
        u_dee_core_model.start_cycle(ctl, 1'b1);
        acc(1'b1, `DEE_OFS_CONTROL, ctl & 16'h3FFF);
        acc(1'b0, `DEE_OFS_CONTROL, 16'h0000);
        chk(q & 32'hC000, 32'h8000);
        tbl(1'b0, n, 16'h0000);
        for (k = 0; busy_out !== 1'b0 && k < 4 * PC; k++) @(posedge clock_in);
        // A cycle that never ends counts as a mismatch here
        chk({31'h0, busy_out}, 32'h0);
        chk({31'h0, memory_done_flag_out}, 32'h1);
        for (k = 0; k < 16; k++)
            exp_mem[(ctl[0] | ctl[3]) ? (n & 48) + k : n] =
                expect_word(ctl, (ctl[0] | ctl[3]) ? (n & 48) + k : n);
        acc(1'b0, `DEE_OFS_DONE_STATUS, 16'h0000);
        chk(q, 32'h1);
        acc(1'b1, `DEE_OFS_DONE_STATUS, 16'h0000);
        acc(1'b0, `DEE_OFS_DONE_STATUS, 16'h0000);
        chk(q, 32'h0);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        foreach (exp_mem[j]) exp_mem[j] = 16'h0000;
        foreach (lat[j]) lat[j] = 16'h0000;
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        acc(1'b0, `DEE_OFS_CONTROL, 16'h0000);
        chk(q, 32'h0);
        u_dee_core_model.start_cycle(16'hC004, 1'b0);
        chk({31'h0, busy_out}, 32'h0);
        acc(1'b1, `DEE_OFS_CONTROL, 16'hC004);
        chk({31'h0, busy_out}, 32'h0);
        acc(1'b1, `DEE_OFS_UNLOCK_KEY, 16'h00AA);
        acc(1'b1, `DEE_OFS_UNLOCK_KEY, 16'h0055);
        acc(1'b1, `DEE_OFS_CONTROL, 16'hC004);
        chk({31'h0, busy_out}, 32'h0);
        $display("refusal test done");
        for (int t = 0; t < 4; t++) begin
            i = (t == 0) ? 63 : $unsigned($random(seed)) % 64;
            lat[i % 16] = 16'($random(seed));
            run(16'h4044, i);
            tbl(1'b1, i, lat[i % 16]);
            acc(1'b0, `DEE_OFS_ADDR_UPPER, 16'h0000);
            chk(q, {24'h000000, `DEE_EE_PAGE});
            run(16'h4004, i);
            tbl(1'b0, i, 16'h0000);
            chk(q, {16'h0000, exp_mem[i]});
        end
        $display("word test done");
        i = ($unsigned($random(seed)) % 4) * 16;
        for (int k = 0; k < 16; k++) begin
            lat[k] = 16'($random(seed));
            tbl(1'b1, i + k, lat[k]);
        end
        run(16'h400A, i + 15);
        check_mem();
        run(16'h4045, i + 5);
        check_mem();
        $display("block test done");
        for (int t = 0; t < 2; t++) begin
            i = $unsigned($random(seed)) % 64;
            acc(1'b1, `DEE_OFS_ADDR_LOW, 16'(i * 2));
            u_dee_core_model.start_cycle(16'h4044, 1'b1);
            {master_clear_in, watchdog_reset_in} <= t ? 2'b01 : 2'b10;
            @(posedge clock_in);
            {master_clear_in, watchdog_reset_in} <= 2'b00;
            acc(1'b0, `DEE_OFS_CONTROL, 16'h0000);
            chk(q & 32'hE000, 32'h6000);
            chk({31'h0, program_error_out}, 32'h1);
            acc(1'b0, `DEE_OFS_ADDR_LOW, 16'h0000);
            chk(q, 32'(i * 2));
            acc(1'b1, `DEE_OFS_CONTROL, 16'h0000);
        end
        check_mem();
        $display("abort test done");
        stop_test();
    end
    // Tests need under 5000 cycles; 20000 means a hang
    initial begin
        #1000000;
        miscompares++;
        stop_test();
    end
endmodule // dee_ctrl_test

// file: pkg/dee_defs.svh
/*
 * Constants of the data EEPROM controller: register offsets, field
 * positions, key values, array geometry and cycle timing.
 * Assumes it is included by its bare name by the package and the bench files.
 */
`ifndef DEE_DEFS_SVH
`define DEE_DEFS_SVH

// =====================================================================
// Register byte offsets on the Avalon-MM slave
`define DEE_OFS_CONTROL      6'h00
`define DEE_OFS_ADDR_LOW     6'h04
`define DEE_OFS_ADDR_UPPER   6'h08
`define DEE_OFS_UNLOCK_KEY   6'h0C
`define DEE_OFS_DONE_STATUS  6'h10
`define DEE_OFS_TABLE_PAGE   6'h14
`define DEE_OFS_TABLE_OFFSET 6'h18
`define DEE_OFS_TABLE_DATA   6'h1C

// =====================================================================
// Control register fields and the done status bit
`define DEE_BIT_START        15
`define DEE_BIT_MODIFY_EN    14
`define DEE_BIT_ERROR        13
`define DEE_OP_HI            6
`define DEE_OP_ERASE         6
`define DEE_OP_BLOCK0        0
`define DEE_OP_BLOCK3        3
`define DEE_BIT_DONE         0

// =====================================================================
// Unlock key values
`define DEE_KEY_FIRST        8'h55
`define DEE_KEY_SECOND       8'hAA

// =====================================================================
// Array geometry and mapping into program space
`define DEE_WORDS            64
`define DEE_IDX_W            6
`define DEE_BLOCK_WORDS      16
`define DEE_EE_PAGE          8'h7F
`define DEE_ERASED           16'hFFFF

// =====================================================================
// Timing: program or erase time at the 20 MHz clock
`define DEE_PROG_TIME_US     2000
`define DEE_CLK_MHZ          20
`define DEE_TIMER_W          16

`endif

// file: pkg/dee_pkg.sv
/*
 * Types of the data EEPROM controller: unlock state and the packed
 * state record of the controller.
 * Assumes dee_defs.svh is on the include path.
 */
`include "dee_defs.svh"

package dee_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_SEEN_FIRST,
        KEY_UNLOCKED
    } dee_key_t;

    typedef struct packed {
        logic                                      ack;
        logic [31:0]                               rdata;
        logic                                      start;
        logic                                      modify_enable;
        logic                                      program_error;
        logic [`DEE_OP_HI:0]                       op;
        logic [15:0]                               addr_low;
        logic [7:0]                                addr_upper;
        logic [7:0]                                table_page;
        logic [15:0]                               table_offset;
        dee_key_t                                  key;
        logic                                      memory_done_flag;
        logic [`DEE_OP_HI:0]                       run_op;
        logic [`DEE_IDX_W-1:0]                     run_idx;
        logic [`DEE_TIMER_W-1:0]                   timer;
        logic [`DEE_WORDS-1:0][15:0]               mem;
        logic [`DEE_BLOCK_WORDS-1:0][15:0]         latch;
    } dee_state_t;

endpackage

// file: rtl/dee_ctrl.sv
/*
 * Data EEPROM controller with its flip-flop array, write latches,
 * unlock key, control register and Avalon-MM register slave.
 * Assumes a single 20 MHz clock, the core issuing table accesses as
 * register accesses, and reset requests arriving as one-cycle pulses
 * from reset logic on the same clock.
 */
// Overview of operation
// - Word read; word or sixteen-word block erase, program
// - Target formed from lower address alone; upper address unused
// - Array sits in program space for table access
// - Table read returns addressed word when idle
// - Program or erase lasts about 2 ms
// - Processor never stalled during a cycle
// - Reads during a cycle return undefined data
// - Start bit set by software, cleared by hardware
// - Modify-enable gates cycles, clear at power-up
// - Error flag set when reset aborts cycle
// - Lower address kept after aborting reset
// - Done flag set by hardware, software clears
// - Start needs 0x55 then 0xAA key writes
// - Modify-enable must precede start write
// - Clearing modify-enable never aborts a cycle
`timescale 1ns/100ps

module dee_ctrl
    import dee_pkg::*;
#(
    parameter int PROG_CYCLES = `DEE_PROG_TIME_US * `DEE_CLK_MHZ
) (
    input  wire logic        clock_in,            // System clock, 20 MHz
    input  wire logic        nrst_in,             // Power-up reset, async, low
    input  wire logic        master_clear_in,     // Master clear reset pulse
    input  wire logic        watchdog_reset_in,   // Watchdog time-out reset pulse
    input  wire logic [5:0]  avs_address_in,      // Byte address
    input  wire logic        avs_read_in,         // Read request
    input  wire logic        avs_write_in,        // Write request
    input  wire logic [31:0] avs_writedata_in,    // Write data
    output logic      [31:0] avs_readdata_out,    // Read data
    output logic             avs_waitrequest_out, // Wait request
    output logic             busy_out,            // Cycle in progress
    output logic             memory_done_flag_out,// Cycle complete flag
    output logic             program_error_out    // Aborted cycle flag
);

    localparam logic [`DEE_TIMER_W-1:0] LAST_TICK = `DEE_TIMER_W'(PROG_CYCLES - 1);

    dee_state_t s;
    dee_state_t next_s;

    logic                   req;
    logic                   wr_fire;
    logic                   aborting_reset;
    logic                   table_hit;
    logic [`DEE_IDX_W-1:0]  table_idx;
    logic [`DEE_IDX_W-1:0]  block_base;
    logic                   run_erase;
    logic                   run_block;
    logic [31:0]            rd_value;
    logic [15:0]            wd;

    // =====================================================================
    // Bus handshake
    assign req                  = avs_read_in | avs_write_in;
    // One wait state; the core keeps running between requests
    assign avs_waitrequest_out  = req & ~s.ack;
    assign wr_fire              = avs_write_in & s.ack;
    assign wd                   = avs_writedata_in[15:0];
    assign aborting_reset       = master_clear_in | watchdog_reset_in;

    assign avs_readdata_out     = s.rdata;
    assign busy_out             = s.start;
    assign memory_done_flag_out = s.memory_done_flag;
    assign program_error_out    = s.program_error;

    // =====================================================================
    // Table access decode
    assign table_hit  = (s.table_page == `DEE_EE_PAGE);
    assign table_idx  = s.table_offset[`DEE_IDX_W:1];
    assign block_base = {s.run_idx[`DEE_IDX_W-1:4], 4'h0};
    assign run_erase  = s.run_op[`DEE_OP_ERASE];
    assign run_block  = s.run_op[`DEE_OP_BLOCK0] | s.run_op[`DEE_OP_BLOCK3];

    // =====================================================================
    // Read multiplexer
    always_comb begin
        rd_value = 32'h0000_0000;
        case (avs_address_in)
            `DEE_OFS_CONTROL: begin
                rd_value[`DEE_BIT_START]     = s.start;
                rd_value[`DEE_BIT_MODIFY_EN] = s.modify_enable;
                rd_value[`DEE_BIT_ERROR]     = s.program_error;
                rd_value[`DEE_OP_HI:0]       = s.op;
            end
            `DEE_OFS_ADDR_LOW:     rd_value[15:0] = s.addr_low;
            `DEE_OFS_ADDR_UPPER:   rd_value[7:0]  = s.addr_upper;
            `DEE_OFS_DONE_STATUS:  rd_value[`DEE_BIT_DONE] = s.memory_done_flag;
            `DEE_OFS_TABLE_PAGE:   rd_value[7:0]  = s.table_page;
            `DEE_OFS_TABLE_OFFSET: rd_value[15:0] = s.table_offset;
            `DEE_OFS_TABLE_DATA: begin
                // Undefined while a cycle runs: the word is shown as zero
                if (table_hit && !s.start) begin
                    rd_value[15:0] = s.mem[table_idx];
                end
            end
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // =====================================================================
    // Next state
    always_comb begin
        next_s     = s;
        next_s.ack = req & ~s.ack;
        if (req && !s.ack) begin
            next_s.rdata = rd_value;
        end

        // Cycle timer and completion
        if (s.start) begin
            if (s.timer == LAST_TICK) begin
                next_s.timer = '0;
                next_s.start = 1'b0;
                next_s.memory_done_flag = 1'b1;
                if (run_block) begin
                    for (int i = 0; i < `DEE_BLOCK_WORDS; i++) begin
                        next_s.mem[`DEE_IDX_W'(block_base + i)] =
                            run_erase ? `DEE_ERASED : s.latch[i];
                    end
                end else begin
                    next_s.mem[s.run_idx] =
                        run_erase ? `DEE_ERASED : s.latch[s.run_idx[3:0]];
                end
            end else begin
                next_s.timer = s.timer + `DEE_TIMER_W'(1);
            end
        end

        // Register writes
        if (wr_fire) begin
            // Any write other than a key write breaks the sequence, the start write included
            if (avs_address_in != `DEE_OFS_UNLOCK_KEY) begin
                next_s.key = KEY_IDLE;
            end
            case (avs_address_in)
                `DEE_OFS_CONTROL: begin
                    // Modify-enable change never touches a running cycle
                    next_s.modify_enable = wd[`DEE_BIT_MODIFY_EN];
                    next_s.program_error = wd[`DEE_BIT_ERROR];
                    if (!s.start) begin
                        next_s.op = wd[`DEE_OP_HI:0];
                    end
                    // Old modify-enable is used, so both bits in one write fail
                    if (wd[`DEE_BIT_START] && !s.start && s.modify_enable
                        && s.key == KEY_UNLOCKED) begin
                        next_s.start   = 1'b1;
                        next_s.timer   = '0;
                        next_s.run_op  = wd[`DEE_OP_HI:0];
                        next_s.run_idx = s.addr_low[`DEE_IDX_W:1];
                    end
                end
                `DEE_OFS_ADDR_LOW:   next_s.addr_low   = wd;
                `DEE_OFS_ADDR_UPPER: next_s.addr_upper = wd[7:0];
                `DEE_OFS_UNLOCK_KEY: begin
                    if (wd[7:0] == `DEE_KEY_FIRST) begin
                        next_s.key = KEY_SEEN_FIRST;
                    end else if (wd[7:0] == `DEE_KEY_SECOND && s.key == KEY_SEEN_FIRST) begin
                        next_s.key = KEY_UNLOCKED;
                    end else begin
                        next_s.key = KEY_IDLE;
                    end
                end
                `DEE_OFS_DONE_STATUS: begin
                    // Completion in the same cycle wins over the clear
                    if (!wd[`DEE_BIT_DONE] && !(s.start && s.timer == LAST_TICK)) begin
                        next_s.memory_done_flag = 1'b0;
                    end
                end
                `DEE_OFS_TABLE_PAGE:   next_s.table_page   = wd[7:0];
                `DEE_OFS_TABLE_OFFSET: next_s.table_offset = wd;
                `DEE_OFS_TABLE_DATA: begin
                    // Table store loads a latch and captures its address
                    if (table_hit) begin
                        next_s.latch[table_idx[3:0]] = wd;
                        next_s.addr_low   = s.table_offset;
                        next_s.addr_upper = s.table_page;
                    end
                end
                default: next_s.key = KEY_IDLE;
            endcase
        end

        // Reset that aborts a cycle; address registers are left alone
        if (aborting_reset) begin
            if (s.start) begin
                next_s.program_error = 1'b1;
            end
            next_s.start = 1'b0;
            next_s.timer = '0;
            next_s.key   = KEY_IDLE;
            next_s.ack   = 1'b0;
        end
    end

    // =====================================================================
    // State register; array contents do not survive power-up reset
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule // dee_ctrl
